// file: common/ascf_defs.svh
// register offsets, field positions, reset values and timing counts for the sequence start block
`ifndef ASCF_DEFS_SVH
`define ASCF_DEFS_SVH

// ****************************************
// register indices and byte addresses, four bytes to each index
// ****************************************
`define ASCF_IDX_START      4'h5
`define ASCF_IDX_CONFIG     4'h3
`define ASCF_IDX_STATUS     4'h6
`define ASCF_IDX_RESULT     4'h8
`define ASCF_ADDR_START     12'h014
`define ASCF_ADDR_CONFIG    12'h00C
`define ASCF_ADDR_STATUS    12'h018
`define ASCF_ADDR_RESULT    12'h020

// ****************************************
// field positions
// ****************************************
`define ASCF_BIT_RJUST      7
`define ASCF_BIT_SIGNED     6
`define ASCF_BIT_SCAN       5
`define ASCF_BIT_MULTI      4
`define ASCF_BIT_LOWRES     7
`define ASCF_BIT_CMPL       7
`define ASCF_BIT_OVR        5

// ****************************************
// reset values and counts
// ****************************************
`define ASCF_START_RST      8'h00
`define ASCF_CONFIG_RST     8'h00
`define ASCF_CONV_TIME_NS   500
`define ASCF_CONV_CYCLES    ((`ASCF_CONV_TIME_NS + 24) / 25)

`endif

// file: common/ascf_pkg.sv
// types shared by the sequence start block
package ascf_pkg;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [1:0]
    {
        SEQ_IDLE,
        SEQ_CONV,
        SEQ_NEXT
    } ascf_seq_state_t;

    typedef struct packed
    {
        logic       rjust;
        logic       signed_sel;
        logic       scan;
        logic       multi;
        logic [2:0] chan;
    } ascf_ctl_t;

endpackage : ascf_pkg

// file: common/ascf_fmt_if.sv
// carrier between sequencer and result formatter
`timescale 1ns/1ps
interface ascf_fmt_if;
    logic        low_res;  // 8-bit mode
    logic        rjust;    // right justify
    logic        sgn;      // signed request
    logic [9:0]  raw;      // raw 10-bit code
    logic [15:0] word;     // formatted word

    modport seq (output low_res, output rjust, output sgn, output raw, input word);
    modport fmt (input low_res, input rjust, input sgn, input raw, output word);
endinterface : ascf_fmt_if

// file: src/ascf_fmt.sv
// result word formatter: width, justification and sign
`timescale 1ns/1ps
module ascf_fmt
(
    ascf_fmt_if.fmt f    // format request and result
);
    // ****************************************
    // format mapping
    // ****************************************
    // right justified forces unsigned whatever the sign bit says
    always_comb
    begin
        logic sgn_eff;
        sgn_eff = f.sgn & ~f.rjust;
        if (f.low_res)
        begin
            if (f.rjust)
                f.word = {8'h00, f.raw[9:2]};
            else
                f.word = {f.raw[9] ^ sgn_eff, f.raw[8:2], 8'h00};
        end
        else
        begin
            if (f.rjust)
                f.word = {6'h00, f.raw};
            else
                f.word = {f.raw[9] ^ sgn_eff, f.raw[8:0], 6'h00};
        end
    end
endmodule : ascf_fmt

// file: src/ascf_chan.sv
// wrapping channel code stepper
`timescale 1ns/1ps
module ascf_chan
#(
    parameter int CW = 3
)
(
    input  wire logic [CW-1:0] cur_i,   // present channel
    input  wire logic          multi_i, // multi channel mode
    output logic      [CW-1:0] nxt_o    // channel for next conversion
);
    // ****************************************
    // step logic
    // ****************************************
    // natural binary overflow gives the last-to-first wrap
    always_comb
    begin
        if (multi_i)
            nxt_o = cur_i + {{(CW-1){1'b0}}, 1'b1};
        else
            nxt_o = cur_i;
    end
endmodule : ascf_chan

// file: src/ascf_top.sv
// sequence start register, sequencer and result format control
// Functional notes
// - any start register write aborts running sequence and starts a new one
// - start register at index 0x05, readable and writable anytime
// - bit 7: zero left justified, one right justified
// - bit 6: zero unsigned, one two's complement signed
// - right justified results are always unsigned, sign bit ignored
// - bit 5: zero single sequence, one continuous scan
// - bit 4 zero: every conversion uses the selected channel
// - multi channel: first uses code, each following one uses the previous code plus one
// - channel code at maximum wraps to minimum
// - three-bit code picks inputs zero to seven in binary order
// - 8-bit: left in bits 8-15, right unsigned in bits 0-7
// - 10-bit: left in bits 6-15, right unsigned in bits 0-9
// - left signed equals unsigned with msb inverted, low bits zero
// - low resolution bit: zero 10-bit, one 8-bit results
// - start write clears complete flag, overrun flag and conversion counter
`timescale 1ns/1ps
`include "ascf_defs.svh"
module ascf_top
#(
    parameter int CONV_CYCLES = `ASCF_CONV_CYCLES
)
(
    input  wire logic        core_clk_i,   // bus clock, 40 MHz
    input  wire logic        srst_i,       // sync reset, active high
    input  wire logic        psel_i,       // apb select
    input  wire logic        penable_i,    // apb enable
    input  wire logic        pwrite_i,     // apb direction
    input  wire logic [11:0] paddr_i,      // apb byte address
    input  wire logic [31:0] pwdata_i,     // apb write data
    output logic      [31:0] prdata_o,     // apb read data
    output logic             pready_o,     // apb ready
    output logic             pslverr_o,    // apb error
    input  wire logic [3:0]  seq_len_i,    // conversions per sequence, 0 means 8
    input  wire logic        trig_i,       // external trigger pulse
    input  wire logic [9:0]  conv_data_i,  // raw converter code
    output logic      [2:0]  chan_sel_o,   // analog input being converted
    output logic             conv_busy_o,  // sequence running
    output logic      [15:0] result_o      // last formatted result
);
    // ****************************************
    // registers
    // ****************************************
    ascf_pkg::ascf_ctl_t          ctl_ff, nxt_ctl;
    logic                         lowres_ff, nxt_lowres;
    logic                         cmpl_ff, nxt_cmpl;
    logic                         ovr_ff, nxt_ovr;
    logic [2:0]                   cnt_ff, nxt_cnt;
    logic [2:0]                   chan_ff, nxt_chan;
    logic [3:0]                   len_ff, nxt_len;
    logic [3:0]                   done_ff, nxt_done;
    logic [15:0]                  tmr_ff, nxt_tmr;
    logic [15:0]                  res_ff, nxt_res;
    logic [31:0]                  rdata_ff, nxt_rdata;
    ascf_pkg::ascf_seq_state_t    st_ff, nxt_st;
    logic [2:0]                   chan_step;
    logic                         wr_acc, rd_acc, wr_start, wr_cfg, wr_stat, hit;
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

    ascf_fmt_if fmt_bus ();

    // ****************************************
    // apb decode
    // ****************************************
    // zero wait states: every access completes in its first access cycle
    assign wr_acc   = psel_i & penable_i & pwrite_i;
    assign rd_acc   = psel_i & ~penable_i & ~pwrite_i;
    assign hit      = (paddr_i == `ASCF_ADDR_START) | (paddr_i == `ASCF_ADDR_CONFIG) |
                      (paddr_i == `ASCF_ADDR_STATUS) | (paddr_i == `ASCF_ADDR_RESULT);
    assign wr_start = wr_acc & (paddr_i == `ASCF_ADDR_START);
    assign wr_cfg   = wr_acc & (paddr_i == `ASCF_ADDR_CONFIG);
    assign wr_stat  = wr_acc & (paddr_i == `ASCF_ADDR_STATUS);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o  = rdata_ff;

    // ****************************************
    // helpers
    // ****************************************
    ascf_chan #(.CW(3)) u_chan
    (
        .cur_i   (chan_ff),
        .multi_i (ctl_ff.multi),
        .nxt_o   (chan_step)
    );

    assign fmt_bus.low_res = lowres_ff;
    assign fmt_bus.rjust   = ctl_ff.rjust;
    assign fmt_bus.sgn     = ctl_ff.signed_sel;
    assign fmt_bus.raw     = conv_data_i;

    ascf_fmt u_fmt
    (
        .f (fmt_bus)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        nxt_ctl    = ctl_ff;
        nxt_lowres = lowres_ff;
        nxt_cmpl   = cmpl_ff;
        nxt_ovr    = ovr_ff;
        nxt_cnt    = cnt_ff;
        nxt_chan   = chan_ff;
        nxt_len    = len_ff;
        nxt_done   = done_ff;
        nxt_tmr    = tmr_ff;
        nxt_res    = res_ff;
        nxt_st     = st_ff;
        nxt_rdata  = rdata_ff;
        if (wr_cfg)
            nxt_lowres = pwdata_i[`ASCF_BIT_LOWRES];
        // status write-one-to-clear; hardware set below wins
        if (wr_stat && pwdata_i[`ASCF_BIT_CMPL])
            nxt_cmpl = 1'b0;
        if (wr_stat && pwdata_i[`ASCF_BIT_OVR])
            nxt_ovr = 1'b0;
        if (trig_i && st_ff != ascf_pkg::SEQ_IDLE)
            nxt_ovr = 1'b1;
        case (st_ff)
            ascf_pkg::SEQ_IDLE:
                nxt_tmr = 16'h0000;
            ascf_pkg::SEQ_CONV:
            begin
                if (tmr_ff == CONV_LAST)
                begin
                    nxt_res  = fmt_bus.word;
                    nxt_tmr  = 16'h0000;
                    nxt_st   = ascf_pkg::SEQ_NEXT;
                end
                else
                    nxt_tmr = tmr_ff + 16'h0001;
            end
            ascf_pkg::SEQ_NEXT:
            begin
                nxt_cnt  = cnt_ff + 3'h1;
                nxt_chan = chan_step;
                nxt_st   = ascf_pkg::SEQ_CONV;
                if (done_ff + 4'h1 == len_ff)
                begin
                    nxt_cmpl = 1'b1;
                    nxt_done = 4'h0;
                    nxt_cnt  = 3'h0;
                    nxt_chan = ctl_ff.chan;
                    if (!ctl_ff.scan)
                        nxt_st = ascf_pkg::SEQ_IDLE;
                end
                else
                    nxt_done = done_ff + 4'h1;
            end
            default:
                nxt_st = ascf_pkg::SEQ_IDLE;
        endcase
        // a start write overrides any sequence progress
        if (wr_start)
        begin
            nxt_ctl   = ascf_pkg::ascf_ctl_t'({pwdata_i[7:4], pwdata_i[2:0]});
            nxt_chan  = pwdata_i[2:0];
            nxt_len   = (seq_len_i == 4'h0) ? 4'h8 : seq_len_i;
            nxt_cmpl  = 1'b0;
            nxt_ovr   = 1'b0;
            nxt_cnt   = 3'h0;
            nxt_done  = 4'h0;
            nxt_tmr   = 16'h0000;
            nxt_st    = ascf_pkg::SEQ_CONV;
        end
        if (rd_acc)
        begin
            case (paddr_i)
                `ASCF_ADDR_START:
                    nxt_rdata = {24'h000000, ctl_ff.rjust, ctl_ff.signed_sel,
                                 ctl_ff.scan, ctl_ff.multi, 1'b0, ctl_ff.chan};
                `ASCF_ADDR_CONFIG:
                    nxt_rdata = {24'h000000, lowres_ff, 7'h00};
                `ASCF_ADDR_STATUS:
                    nxt_rdata = {24'h000000, cmpl_ff, 1'b0, ovr_ff, 2'b00, cnt_ff};
                `ASCF_ADDR_RESULT:
                    nxt_rdata = {16'h0000, res_ff};
                default:
                    nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // state registers
    // ****************************************
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            ctl_ff    <= ascf_pkg::ascf_ctl_t'(7'h00);
            lowres_ff <= 1'b0;
            cmpl_ff   <= 1'b0;
            ovr_ff    <= 1'b0;
            cnt_ff    <= 3'h0;
            chan_ff   <= 3'h0;
            len_ff    <= 4'h8;
            done_ff   <= 4'h0;
            tmr_ff    <= 16'h0000;
            res_ff    <= 16'h0000;
            rdata_ff  <= 32'h00000000;
            st_ff     <= ascf_pkg::SEQ_IDLE;
        end
        else
        begin
            ctl_ff    <= nxt_ctl;
            lowres_ff <= nxt_lowres;
            cmpl_ff   <= nxt_cmpl;
            ovr_ff    <= nxt_ovr;
            cnt_ff    <= nxt_cnt;
            chan_ff   <= nxt_chan;
            len_ff    <= nxt_len;
            done_ff   <= nxt_done;
            tmr_ff    <= nxt_tmr;
            res_ff    <= nxt_res;
            rdata_ff  <= nxt_rdata;
            st_ff     <= nxt_st;
        end
    end

    assign chan_sel_o  = chan_ff;
    assign conv_busy_o = (st_ff != ascf_pkg::SEQ_IDLE);
    assign result_o    = res_ff;

    // ****************************************
    // checks
    // ****************************************
    // start write: restart, cleared status and fresh settings one cycle later
    chk_start_runs: assert property (@(posedge core_clk_i) disable iff (srst_i)
        wr_start |=> st_ff == ascf_pkg::SEQ_CONV && tmr_ff == 16'h0000)
        else $error("start write did not restart sequence");
    chk_start_clears: assert property (@(posedge core_clk_i) disable iff (srst_i)
        wr_start |=> !cmpl_ff && !ovr_ff && cnt_ff == 3'h0)
        else $error("start write did not clear status");
    chk_start_chan: assert property (@(posedge core_clk_i) disable iff (srst_i)
        wr_start |=> chan_sel_o == $past(pwdata_i[2:0]))
        else $error("channel not loaded from code");
    chk_len_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
        wr_start |=> len_ff == (($past(seq_len_i) == 4'h0) ? 4'h8 : $past(seq_len_i)))
        else $error("sequence length not sampled at start");
    chk_len_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !wr_start |=> $stable(len_ff))
        else $error("sequence length changed mid sequence");

    // channel walk; a start write reloads the channel, so it is left out here
    chk_single_chan: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!ctl_ff.multi && !wr_start && st_ff != ascf_pkg::SEQ_IDLE)
        |=> chan_ff == ctl_ff.chan)
        else $error("single channel mode moved channel");
    chk_multi_step: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (ctl_ff.multi && st_ff == ascf_pkg::SEQ_NEXT && !wr_start && done_ff + 4'h1 != len_ff)
        |=> chan_ff == 3'($past(chan_ff) + 3'h1))
        else $error("multi channel did not step");
    chk_wrap: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (ctl_ff.multi && chan_ff == 3'h7 && st_ff == ascf_pkg::SEQ_NEXT && !wr_start)
        |=> chan_ff == 3'h0 || chan_ff == $past(ctl_ff.chan))
        else $error("channel did not wrap");

    // end of sequence: single stops, scan goes straight on
    chk_single_stop: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!ctl_ff.scan && $rose(cmpl_ff)) |-> st_ff == ascf_pkg::SEQ_IDLE)
        else $error("single sequence did not stop");
    chk_scan_repeat: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (ctl_ff.scan && $rose(cmpl_ff)) |-> st_ff == ascf_pkg::SEQ_CONV)
        else $error("scan sequence did not repeat");

    // result word mapping for every width, justification and sign
    chk_rjust_uns: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (ctl_ff.rjust && !lowres_ff) |-> fmt_bus.word == {6'h00, conv_data_i})
        else $error("right justified result not plain");
    chk_right8: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (ctl_ff.rjust && lowres_ff) |-> fmt_bus.word == {8'h00, conv_data_i[9:2]})
        else $error("8-bit right result misplaced");
    chk_left8: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!ctl_ff.rjust && lowres_ff) |-> fmt_bus.word[7:0] == 8'h00 &&
        fmt_bus.word[14:8] == conv_data_i[8:2])
        else $error("8-bit left result misplaced");
    chk_left10: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!ctl_ff.rjust && !lowres_ff) |-> fmt_bus.word[14:6] == conv_data_i[8:0])
        else $error("10-bit left result misplaced");
    chk_sign_msb: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!ctl_ff.rjust && !lowres_ff) |-> fmt_bus.word[15] ==
        (conv_data_i[9] ^ ctl_ff.signed_sel) && fmt_bus.word[5:0] == 6'h00)
        else $error("10-bit left sign wrong");
    chk_sign8: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!ctl_ff.rjust && lowres_ff) |-> fmt_bus.word[15] ==
        (conv_data_i[9] ^ ctl_ff.signed_sel))
        else $error("8-bit left sign wrong");

    // main scenarios
    cov_scan: cover property (@(posedge core_clk_i) ctl_ff.scan && $rose(cmpl_ff));
    cov_abort: cover property (@(posedge core_clk_i) st_ff == ascf_pkg::SEQ_CONV && wr_start);
    cov_wrap: cover property (@(posedge core_clk_i) ctl_ff.multi && chan_ff == 3'h7
        ##1 chan_ff == 3'h0);
    cov_multi_len: cover property (@(posedge core_clk_i) ctl_ff.multi && $rose(cmpl_ff));
endmodule : ascf_top

// file: tb/ascf_top_bench.sv
// self-checking bench for the sequence start and result format block
`timescale 1ns/1ps
`include "ascf_defs.svh"
module ascf_top_bench;

    // ****************************************
    // signals
    // ****************************************
    logic        core_clk;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  seq_len;
    logic        trig;
    logic [9:0]  conv_data;
    logic [2:0]  chan_sel;
    logic        conv_busy;
    logic [15:0] result;
    logic        track;        // converter data follows the channel
    logic [9:0]  fix_data;     // fixed converter code
    int          err_total;
    int          total_checks;
    logic [31:0] rd;
    logic        er;

    // ****************************************
    // design, clock and converter stand-in
    // ****************************************
    // short conversions keep the run brief
    ascf_top #(.CONV_CYCLES(4)) u_ascf_top
    (
        .core_clk_i (core_clk),
        .srst_i     (srst),
        .psel_i     (psel),
        .penable_i  (penable),
        .pwrite_i   (pwrite),
        .paddr_i    (paddr),
        .pwdata_i   (pwdata),
        .prdata_o   (prdata),
        .pready_o   (pready),
        .pslverr_o  (pslverr),
        .seq_len_i  (seq_len),
        .trig_i     (trig),
        .conv_data_i(conv_data),
        .chan_sel_o (chan_sel),
        .conv_busy_o(conv_busy),
        .result_o   (result)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // code tagged by channel so each result names the input it came from
    always @(posedge core_clk)
        conv_data <= track ? (10'h010 + {7'h00, chan_sel}) : fix_data;

    // ****************************************
    // helpers
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // answer is taken at the rising edge where pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rdat, output logic err);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            err_total++;
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_idle;
        int n;
        n = 0;
        @(posedge core_clk);
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (conv_busy !== 1'b0 && n < 500);
        chk({31'h0, conv_busy}, 32'h0);
    endtask : wait_idle

    function automatic logic [31:0] fmt_exp(input logic lr, input logic rj, input logic sg,
                                           input logic [9:0] raw);
        logic [9:0] v;
        v = lr ? {2'b00, raw[9:2]} : raw;
        if (rj)
            return {22'h0, v};
        if (lr)
            return {16'h0, v[7] ^ sg, v[6:0], 8'h00};
        return {16'h0, v[9] ^ sg, v[8:0], 6'h00};
    endfunction : fmt_exp

    // ****************************************
    // scenarios
    // ****************************************
    task test_regs;
        apb(1'b0, `ASCF_ADDR_START, 32'h0, rd, er);
        chk(rd, {24'h0, `ASCF_START_RST});
        apb(1'b1, `ASCF_ADDR_START, 32'hFFFF_FF25, rd, er);
        apb(1'b0, `ASCF_ADDR_START, 32'h0, rd, er);
        chk(rd, 32'h0000_0025);
        apb(1'b0, 12'h03C, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask : test_regs

    // every resolution, justification and sign pairing, mid-scale and extremes
    task test_format;
        logic [9:0]  raws [3];
        logic [31:0] exp;
        raws = '{10'h200, 10'h3FF, 10'h001};
        for (int i = 0; i < 3; i++)
        begin
            for (int m = 0; m < 8; m++)
            begin
                track    <= 1'b0;
                fix_data <= raws[i];
                seq_len  <= 4'h1;
                apb(1'b1, `ASCF_ADDR_CONFIG, {24'h0, m[2], 7'h00}, rd, er);
                apb(1'b1, `ASCF_ADDR_START, {24'h0, m[1], m[0], 6'h02}, rd, er);
                wait_idle;
                exp = fmt_exp(m[2], m[1], m[0], raws[i]);
                chk({16'h0, result}, exp);
            end
        end
    endtask : test_format

    // start at input six so the walk wraps past the last input
    task test_multi;
        logic [15:0] prev;
        int          n;
        apb(1'b1, `ASCF_ADDR_CONFIG, 32'h0, rd, er);
        track   <= 1'b1;
        seq_len <= 4'h4;
        prev = result;
        apb(1'b1, `ASCF_ADDR_START, 32'h0000_0096, rd, er);
        seq_len <= 4'h1;
        for (int k = 0; k < 4; k++)
        begin
            n = 0;
            do
            begin
                @(negedge core_clk);
                n++;
            end
            while (result === prev && n < 100);
            prev = result;
            chk({16'h0, result}, 32'h0000_0010 + ((6 + k) % 8));
        end
        wait_idle;
    endtask : test_multi

    task test_abort;
        logic bad;
        int   n;
        track    <= 1'b0;
        fix_data <= 10'h155;
        seq_len  <= 4'h1;
        apb(1'b1, `ASCF_ADDR_START, 32'h0000_0031, rd, er);
        repeat (10) @(posedge core_clk);
        trig <= 1'b1;
        @(posedge core_clk);
        trig <= 1'b0;
        repeat (30) @(negedge core_clk);
        chk({31'h0, conv_busy}, 32'h1);
        apb(1'b0, `ASCF_ADDR_STATUS, 32'h0, rd, er);
        chk(rd & 32'h0000_00A0, 32'h0000_00A0);
        seq_len <= 4'h3;
        apb(1'b1, `ASCF_ADDR_START, 32'h0000_0005, rd, er);
        apb(1'b0, `ASCF_ADDR_STATUS, 32'h0, rd, er);
        chk(rd & 32'h0000_00A7, 32'h0);
        bad = 1'b0;
        n = 0;
        @(negedge core_clk);
        while (conv_busy === 1'b1 && n < 500)
        begin
            if (chan_sel !== 3'h5)
                bad = 1'b1;
            @(negedge core_clk);
            n++;
        end
        chk({31'h0, bad}, 32'h0);
        wait_idle;
        repeat (20) @(negedge core_clk);
        chk({31'h0, conv_busy}, 32'h0);
        apb(1'b0, `ASCF_ADDR_STATUS, 32'h0, rd, er);
        chk(rd & 32'h0000_0080, 32'h0000_0080);
    endtask : test_abort

    // a status write clears only the flags written with a one; a one to the overrun bit leaves complete set
    task test_status;
        apb(1'b1, `ASCF_ADDR_CONFIG, 32'h0000_0080, rd, er);
        apb(1'b0, `ASCF_ADDR_CONFIG, 32'h0, rd, er);
        chk(rd, 32'h0000_0080);
        trig <= 1'b1;
        @(posedge core_clk);
        trig <= 1'b0;
        apb(1'b1, `ASCF_ADDR_STATUS, 32'h0000_0020, rd, er);
        apb(1'b0, `ASCF_ADDR_STATUS, 32'h0, rd, er);
        chk(rd & 32'h0000_00A7, 32'h0000_0080);
        apb(1'b1, `ASCF_ADDR_STATUS, 32'h0000_0080, rd, er);
        apb(1'b0, `ASCF_ADDR_STATUS, 32'h0, rd, er);
        chk(rd & 32'h0000_00A7, 32'h0);
    endtask : test_status

    // ****************************************
    // verdict, watchdog and main sequence
    // ****************************************
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // the whole run needs well under this span
    initial
    begin
        #500000;
        err_total++;
        give_verdict;
    end

    initial
    begin
        srst         = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 12'h000;
        pwdata       = 32'h0;
        seq_len      = 4'h1;
        trig         = 1'b0;
        track        = 1'b0;
        fix_data     = 10'h000;
        err_total    = 0;
        total_checks = 0;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        test_regs;
        test_format;
        test_multi;
        test_abort;
        test_status;
        give_verdict;
    end

endmodule : ascf_top_bench
